// ---- design/ate_regs.svh ----
`ifndef ATE_REGS_SVH
`define ATE_REGS_SVH

// Register byte offsets
`define ATE_CTRL_OFS 8'h00
`define ATE_SRC_OFS 8'h04
`define ATE_CMD_OFS 8'h08
`define ATE_SDIV_OFS 8'h0C
`define ATE_CDIV_OFS 8'h10
`define ATE_DLY_OFS 8'h14
`define ATE_NCHAN_OFS 8'h18
`define ATE_SCNT_OFS 8'h1C
`define ATE_PRE_OFS 8'h20
`define ATE_BSIZE_OFS 8'h24
`define ATE_STAT_OFS 8'h28
`define ATE_BUF_OFS 8'h2C

// Control register fields
`define ATE_C_FINITE 0
`define ATE_C_REFMODE 1
`define ATE_C_BEGEN 2
`define ATE_C_BEGEDGE 3
`define ATE_C_REFEDGE 4
`define ATE_C_PAUSEEN 5
`define ATE_C_PAUSELVL 6
`define ATE_C_HOLDPOL 7
`define ATE_C_SINGLE 8
`define ATE_C_CTB20 9
`define ATE_C_SINT 10
`define ATE_C_CINT 11
`define ATE_C_SEDGE 12
`define ATE_C_CEDGE 13
`define ATE_C_RTCONV 14
`define ATE_C_RTBEG 15
`define ATE_C_RTHOLD 16
`define ATE_C_W 17

// Source select fields, two bits each
`define ATE_S_BEG 0
`define ATE_S_REF 2
`define ATE_S_PAUSE 4
`define ATE_S_SAMP 6
`define ATE_S_CONV 8
`define ATE_S_STB 10
`define ATE_S_W 12

// Command strobes
`define ATE_CMD_START 0
`define ATE_CMD_STOP 1

// Reset values
`define ATE_CTRL_RST 17'h10080
`define ATE_SRC_RST 12'h000
`define ATE_SDIV_RST 16'h0001
`define ATE_CDIV_RST 16'h0001
`define ATE_SDLY_RST 16'h0002
`define ATE_CDLY_RST 16'h0003
`define ATE_NCHAN_RST 8'h01
`define ATE_SCNT_RST 16'h0001

`endif

// ---- design/ate_pkg.sv ----
package ate_pkg;
	typedef enum logic [1:0] {
		ATE_IDLE,
		ATE_ARM,
		ATE_RUN
	} ate_state_t;

	typedef enum logic [1:0] {
		ATE_TB_20M,
		ATE_TB_100K,
		ATE_TB_TERM,
		ATE_TB_OFF
	} ate_tick_sel_t;
endpackage : ate_pkg

// ---- design/ate_engine.sv ----
`timescale 1ns/10ps
`include "ate_regs.svh"
// Behaviour
// - Routed conversion pulse drives active low
// - Sample-to-first-conversion delay, default three ticks
// - Ignore pulses until acquisition begins
// - Drop sample pulses until conversions complete
// - Drop conversions outside an accepted sample
// - Drop extra conversions until next sample
// - Single signal: one conversion per sample edge
// - Conversion tick from sample or 20 MHz
// - Conversion timebase never reaches a terminal
// - Hold-done strobe after every conversion start
// - Hold-done polarity programmable, normally rising
// - Begin on trigger or software command
// - End on count, reference, or software
// - Begin trigger source and edge selectable
// - Routed begin trigger is active-high pulse
// - Post-trigger count is buffer minus pretrigger
// - Ignore reference before pretrigger samples captured
// - Full buffer discards oldest while waiting
// - Store post-trigger samples, then stop
// - Reference source and edge selectable
// - Internal sample clock halts during pause
// - Pause active level programmable
// - Conversion divider counts, fires, reloads per sample
// - Begin-to-first-sample delay, default two ticks
module ate_engine #(
	parameter int NTERM = 4,
	parameter int DEPTH = 16,
	parameter int DW = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tb20_tick,
	input wire logic tb100k_tick,
	input wire logic [NTERM-1:0] programmable_function_terminal_in,
	input wire logic [DW-1:0] adc_data,
	output logic conversion_pulse,
	output logic hold_done_strobe,
	output logic [2:0] term_out,
	output logic [2:0] term_oe,
	output ate_pkg::ate_state_t state
);
	import ate_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// Two-bit source fields fix the terminal count at four
	if (NTERM != 4 || DEPTH < 2 || DEPTH > 65535 || DW < 1 || DW > 32) begin : g_bad_param
		$error("ate_engine: unsupported parameters");
	end

	logic [`ATE_C_W-1:0] ctrl_reg;
	logic [`ATE_S_W-1:0] src_reg;
	logic [15:0] sdiv_reg, cdiv_reg, sdly_reg, cdly_reg, scnt_reg, pre_reg, bsize_reg;
	logic [7:0] nchan_reg;
	logic start_cmd, stop_cmd;

	// Synchroniser stages; only s2/s3 feed the logic
	logic [NTERM-1:0] s1_reg, s2_reg, s3_reg, rise, fall;
	genvar gi;
	generate
		for (gi = 0; gi < NTERM; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_reg[gi] <= 1'b0;
					s2_reg[gi] <= 1'b0;
					s3_reg[gi] <= 1'b0;
				end else begin
					s1_reg[gi] <= programmable_function_terminal_in[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
				end
			end
			assign rise[gi] = s2_reg[gi] & ~s3_reg[gi];
			assign fall[gi] = ~s2_reg[gi] & s3_reg[gi];
		end
	endgenerate

	function automatic logic edge_of(input logic [1:0] sel, input logic falling,
		input logic [NTERM-1:0] r, input logic [NTERM-1:0] f);
		edge_of = falling ? f[sel] : r[sel];
	endfunction

	logic begin_edge, ref_edge, samp_ext, conv_ext, pause_act;
	assign begin_edge = edge_of(src_reg[`ATE_S_BEG+:2], ctrl_reg[`ATE_C_BEGEDGE], rise, fall);
	assign ref_edge = edge_of(src_reg[`ATE_S_REF+:2], ctrl_reg[`ATE_C_REFEDGE], rise, fall);
	assign samp_ext = edge_of(src_reg[`ATE_S_SAMP+:2], ctrl_reg[`ATE_C_SEDGE], rise, fall);
	assign conv_ext = edge_of(src_reg[`ATE_S_CONV+:2], ctrl_reg[`ATE_C_CEDGE], rise, fall);
	assign pause_act = ctrl_reg[`ATE_C_PAUSEEN] &&
		(s2_reg[src_reg[`ATE_S_PAUSE+:2]] == ctrl_reg[`ATE_C_PAUSELVL]);

	logic samp_tick, conv_tick;
	always_comb begin
		case (ate_tick_sel_t'(src_reg[`ATE_S_STB+:2]))
			ATE_TB_20M: samp_tick = tb20_tick;
			ATE_TB_100K: samp_tick = tb100k_tick;
			ATE_TB_TERM: samp_tick = rise[0];
			default: samp_tick = 1'b0;
		endcase
	end
	assign conv_tick = ctrl_reg[`ATE_C_CTB20] ? tb20_tick : samp_tick;

	// Acquisition core
	logic running;
	logic [15:0] scnt_dn_reg, ccnt_dn_reg, samp_left_reg, post_left_reg, pre_seen_reg;
	logic [7:0] conv_num_reg;
	logic in_sample_reg, trig_reg, done_reg, ovf_reg;
	logic samp_int, conv_int, samp_raw, conv_raw, samp_acc, conv_acc, samp_end;
	logic begin_now, stop_now, single;

	assign running = (state == ATE_RUN);
	assign single = ctrl_reg[`ATE_C_SINGLE];
	assign samp_int = running && !pause_act && samp_tick && (scnt_dn_reg <= 16'h0001);
	assign conv_int = in_sample_reg && conv_tick && (ccnt_dn_reg <= 16'h0001);
	assign samp_raw = single ? samp_ext : (ctrl_reg[`ATE_C_SINT] ? samp_int : samp_ext);
	assign conv_raw = single ? samp_ext : (ctrl_reg[`ATE_C_CINT] ? conv_int : conv_ext);
	assign samp_acc = running && samp_raw && !in_sample_reg;
	// Same edge opens the sample and converts when one signal drives both
	assign conv_acc = running && conv_raw && (in_sample_reg || (single && samp_acc));
	assign samp_end = conv_acc && (conv_num_reg + 8'h01 >= nchan_reg);
	assign begin_now = (state == ATE_ARM) &&
		(ctrl_reg[`ATE_C_BEGEN] ? begin_edge : 1'b1);

	always_comb begin
		stop_now = 1'b0;
		if (running) begin
			if (stop_cmd) begin
				stop_now = 1'b1;
			end else if (ctrl_reg[`ATE_C_REFMODE]) begin
				if (trig_reg && samp_end && post_left_reg <= 16'h0001) begin
					stop_now = 1'b1;
				end else if (!trig_reg && ref_edge && pre_seen_reg >= pre_reg &&
					bsize_reg <= pre_reg) begin
					stop_now = 1'b1;
				end
			end else if (ctrl_reg[`ATE_C_FINITE] && samp_end && samp_left_reg <= 16'h0001) begin
				stop_now = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ATE_IDLE;
		end else begin
			case (state)
				ATE_IDLE: if (start_cmd) state <= ATE_ARM;
				ATE_ARM: begin
					if (stop_cmd) begin
						state <= ATE_IDLE;
					end else if (begin_now) begin
						state <= ATE_RUN;
					end
				end
				ATE_RUN: if (stop_now) state <= ATE_IDLE;
				default: state <= ATE_IDLE;
			endcase
		end
	end

	// Sample divider: first pulse after the begin delay, then every divide ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scnt_dn_reg <= `ATE_SDLY_RST;
		end else if (begin_now) begin
			scnt_dn_reg <= sdly_reg;
		end else if (running && samp_tick && !pause_act) begin
			scnt_dn_reg <= (scnt_dn_reg <= 16'h0001) ? sdiv_reg : scnt_dn_reg - 16'h0001;
		end
	end

	// Conversion divider restarts from the delay on each accepted sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ccnt_dn_reg <= `ATE_CDLY_RST;
		end else if (samp_acc || samp_end || !running) begin
			ccnt_dn_reg <= cdly_reg;
		end else if (in_sample_reg && conv_tick) begin
			ccnt_dn_reg <= (ccnt_dn_reg <= 16'h0001) ? cdiv_reg : ccnt_dn_reg - 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_sample_reg <= 1'b0;
			conv_num_reg <= 8'h00;
		end else if (!running || samp_end) begin
			in_sample_reg <= 1'b0;
			conv_num_reg <= 8'h00;
		end else begin
			if (samp_acc) in_sample_reg <= 1'b1;
			if (conv_acc) conv_num_reg <= conv_num_reg + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_left_reg <= `ATE_SCNT_RST;
			pre_seen_reg <= 16'h0000;
			trig_reg <= 1'b0;
			post_left_reg <= 16'h0000;
		end else if (begin_now) begin
			samp_left_reg <= scnt_reg;
			pre_seen_reg <= 16'h0000;
			trig_reg <= 1'b0;
		end else if (running) begin
			if (samp_end) samp_left_reg <= samp_left_reg - 16'h0001;
			if (samp_end && pre_seen_reg != 16'hFFFF) pre_seen_reg <= pre_seen_reg + 16'h0001;
			if (!trig_reg && ref_edge && pre_seen_reg >= pre_reg) begin
				trig_reg <= 1'b1;
				post_left_reg <= bsize_reg - pre_reg;
			end else if (trig_reg && samp_end) begin
				post_left_reg <= post_left_reg - 16'h0001;
			end
		end
	end

	// Sample buffer, circular, oldest entry at head
	logic [DW-1:0] mem_reg [DEPTH];
	logic [AW-1:0] head_reg, tail_reg;
	logic [15:0] count_reg, cap;
	logic buf_pop, buf_full;
	assign cap = (bsize_reg == 16'h0000 || bsize_reg > 16'(DEPTH)) ? 16'(DEPTH) : bsize_reg;
	assign buf_full = (count_reg >= cap);
	assign buf_pop = psel && penable && !pwrite && paddr == `ATE_BUF_OFS && count_reg != 16'h0000;

	function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
		wrap = (32'(p) + 1 >= DEPTH) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge pclk) begin
		if (samp_end) mem_reg[tail_reg] <= adc_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			head_reg <= '0;
			tail_reg <= '0;
			count_reg <= 16'h0000;
			ovf_reg <= 1'b0;
		end else if (begin_now) begin
			head_reg <= '0;
			tail_reg <= '0;
			count_reg <= 16'h0000;
			ovf_reg <= 1'b0;
		end else if (samp_end) begin
			tail_reg <= wrap(tail_reg);
			if (buf_full || buf_pop) begin
				head_reg <= wrap(head_reg);
				ovf_reg <= ovf_reg | buf_full;
			end else begin
				count_reg <= count_reg + 16'h0001;
			end
		end else if (buf_pop) begin
			head_reg <= wrap(head_reg);
			count_reg <= count_reg - 16'h0001;
		end
	end

	// Outputs
	logic begin_pulse_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conversion_pulse <= 1'b0;
			hold_done_strobe <= 1'b0;
			begin_pulse_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			conversion_pulse <= conv_acc;
			// Strobe trails conversion start by one cycle
			hold_done_strobe <= conversion_pulse ^ ~ctrl_reg[`ATE_C_HOLDPOL];
			begin_pulse_reg <= begin_now;
			if (begin_now) begin
				done_reg <= 1'b0;
			end else if (stop_now) begin
				done_reg <= 1'b1;
			end
		end
	end

	// Conversion timebase has no terminal route
	always_comb begin
		term_out[0] = ~conversion_pulse;
		term_out[1] = begin_pulse_reg;
		term_out[2] = hold_done_strobe;
		term_oe = ctrl_reg[`ATE_C_RTHOLD:`ATE_C_RTCONV];
	end

	// APB slave, zero wait states
	logic acc_w, hit;
	assign pready = 1'b1;
	assign acc_w = psel && penable && pwrite;
	always_comb begin
		hit = 1'b1;
		case (paddr)
			`ATE_CTRL_OFS, `ATE_SRC_OFS, `ATE_CMD_OFS, `ATE_SDIV_OFS, `ATE_CDIV_OFS,
			`ATE_DLY_OFS, `ATE_NCHAN_OFS, `ATE_SCNT_OFS, `ATE_PRE_OFS, `ATE_BSIZE_OFS,
			`ATE_STAT_OFS, `ATE_BUF_OFS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !hit;
	assign start_cmd = acc_w && paddr == `ATE_CMD_OFS && pwdata[`ATE_CMD_START];
	assign stop_cmd = acc_w && paddr == `ATE_CMD_OFS && pwdata[`ATE_CMD_STOP];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `ATE_CTRL_RST;
			src_reg <= `ATE_SRC_RST;
			sdiv_reg <= `ATE_SDIV_RST;
			cdiv_reg <= `ATE_CDIV_RST;
			sdly_reg <= `ATE_SDLY_RST;
			cdly_reg <= `ATE_CDLY_RST;
			nchan_reg <= `ATE_NCHAN_RST;
			scnt_reg <= `ATE_SCNT_RST;
			pre_reg <= 16'h0000;
			bsize_reg <= 16'h0000;
		end else if (acc_w && state == ATE_IDLE) begin
			// Configuration frozen while armed or running
			case (paddr)
				`ATE_CTRL_OFS: ctrl_reg <= pwdata[`ATE_C_W-1:0];
				`ATE_SRC_OFS: src_reg <= pwdata[`ATE_S_W-1:0];
				`ATE_SDIV_OFS: sdiv_reg <= pwdata[15:0];
				`ATE_CDIV_OFS: cdiv_reg <= pwdata[15:0];
				`ATE_DLY_OFS: begin
					sdly_reg <= pwdata[15:0];
					cdly_reg <= pwdata[31:16];
				end
				`ATE_NCHAN_OFS: nchan_reg <= pwdata[7:0];
				`ATE_SCNT_OFS: scnt_reg <= pwdata[15:0];
				`ATE_PRE_OFS: pre_reg <= pwdata[15:0];
				`ATE_BSIZE_OFS: bsize_reg <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		case (paddr)
			`ATE_CTRL_OFS: prdata = {15'h0000, ctrl_reg};
			`ATE_SRC_OFS: prdata = {20'h00000, src_reg};
			`ATE_SDIV_OFS: prdata = {16'h0000, sdiv_reg};
			`ATE_CDIV_OFS: prdata = {16'h0000, cdiv_reg};
			`ATE_DLY_OFS: prdata = {cdly_reg, sdly_reg};
			`ATE_NCHAN_OFS: prdata = {24'h000000, nchan_reg};
			`ATE_SCNT_OFS: prdata = {16'h0000, scnt_reg};
			`ATE_PRE_OFS: prdata = {16'h0000, pre_reg};
			`ATE_BSIZE_OFS: prdata = {16'h0000, bsize_reg};
			`ATE_STAT_OFS: prdata = {count_reg, 9'h000, ovf_reg, done_reg, trig_reg,
				in_sample_reg, pause_act, 2'(state)};
			`ATE_BUF_OFS: prdata = (count_reg == 16'h0000) ? 32'h00000000 :
				32'(mem_reg[head_reg]);
			default: prdata = 32'h00000000;
		endcase
	end
endmodule : ate_engine

// ---- bench/ate_engine_properties.sv ----
`timescale 1ns/10ps
`include "ate_regs.svh"
module ate_engine_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic conversion_pulse,
	input wire logic hold_done_strobe,
	input wire logic [2:0] term_out,
	input wire ate_pkg::ate_state_t state
);
	import ate_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic cmd_wr;
	assign cmd_wr = psel && penable && pwrite && paddr == `ATE_CMD_OFS;
	a_conv_low: assert property (term_out[0] == !conversion_pulse)
		else $error("conversion pin not inverse of pulse");
	a_hold_route: assert property (term_out[2] == hold_done_strobe)
		else $error("hold pin differs from strobe");
	a_hold_cause: assert property (state == ATE_RUN && $past(state) == ATE_RUN &&
		$past(state, 2) == ATE_RUN |-> $changed(hold_done_strobe) ==
		($past(conversion_pulse) != $past(conversion_pulse, 2)))
		else $error("hold strobe not tied to conversion");
	a_gate_idle: assert property ($past(state) != ATE_RUN && $past(state, 2) != ATE_RUN
		|-> !conversion_pulse)
		else $error("conversion outside acquisition");
	a_begin_width: assert property (term_out[1] |=> !term_out[1])
		else $error("begin pulse longer than one cycle");
	a_begin_order: assert property (term_out[1] |-> state == ATE_RUN &&
		$past(state) == ATE_ARM)
		else $error("begin pulse without arm to run");
	a_start_arm: assert property (cmd_wr && pwdata[0] && !pwdata[1] && state == ATE_IDLE
		|=> state == ATE_ARM)
		else $error("start command not taken");
	a_stop_idle: assert property (cmd_wr && pwdata[1] |=> state == ATE_IDLE)
		else $error("stop command not taken");
	c_conv: cover property (conversion_pulse);
	c_begin: cover property (term_out[1]);
	c_end: cover property (state == ATE_RUN ##1 state == ATE_IDLE);
endmodule : ate_engine_properties

bind ate_engine ate_engine_properties u_ate_engine_properties (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.conversion_pulse(conversion_pulse), .hold_done_strobe(hold_done_strobe),
	.term_out(term_out), .state(state));

// ---- bench/ate_far_model.sv ----
`timescale 1ns/10ps
module ate_far_model (
	input wire logic pclk,
	input wire logic conversion_pulse,
	output logic [3:0] programmable_function_terminal,
	output logic [15:0] adc_data
);
	initial begin
		programmable_function_terminal = 4'h0;
		adc_data = 16'h0000;
	end
	// Fresh result per conversion so a stale capture shows as a repeat
	always @(posedge pclk) if (conversion_pulse) adc_data <= adc_data + 16'h0001;
	// Held four edges, longer than the three-flop synchroniser needs
	task automatic level(input int i, input logic v);
		programmable_function_terminal[i] <= v;
		repeat (4) @(posedge pclk);
	endtask : level
	task automatic pulse(input int i);
		level(i, 1'b1);
		level(i, 1'b0);
	endtask : pulse
endmodule : ate_far_model

// ---- bench/acquisition_timing_engine_tb.sv ----
`timescale 1ns/10ps
`include "ate_regs.svh"
module acquisition_timing_engine_tb;
	import ate_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erv, tb20_tick;
	logic conversion_pulse, hold_done_strobe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [3:0] programmable_function_terminal;
	logic [15:0] adc_data;
	logic [2:0] term_out, term_oe, tdiv;
	logic tb100k_tick;
	ate_state_t state;
	int fail_count, check_count, conv_cnt, base;
	int seq[9] = '{1, 0, 0, 1, 1, 1, 0, 1, 1};
	logic [7:0] ra[4] = '{`ATE_CTRL_OFS, `ATE_DLY_OFS, `ATE_NCHAN_OFS, `ATE_SCNT_OFS};
	logic [31:0] rv[4] = '{32'h00010080, 32'h00030002, 32'h00000001, 32'h00000001};

	ate_engine u_ate_engine (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tb20_tick(tb20_tick), .tb100k_tick(tb100k_tick),
		.programmable_function_terminal_in(programmable_function_terminal), .adc_data(adc_data),
		.conversion_pulse(conversion_pulse), .hold_done_strobe(hold_done_strobe),
		.term_out(term_out), .term_oe(term_oe), .state(state));
	ate_far_model u_ate_far_model (.pclk(pclk), .conversion_pulse(conversion_pulse),
		.programmable_function_terminal(programmable_function_terminal), .adc_data(adc_data));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) tb20_tick <= ~tb20_tick;
	// Slow timebase: one tick in eight clocks
	always @(posedge pclk) tdiv <= tdiv + 3'h1;
	assign tb100k_tick = (tdiv == 3'h7);
	always @(posedge pclk) if (conversion_pulse === 1'b1) conv_cnt <= conv_cnt + 1;

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fail_count++;
			complete_run();
		end
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(1'b0, a, 32'h00000000);
		chk(rdv & m, exp);
	endtask : rd
	task automatic wait_state(input ate_state_t s);
		int k;
		k = 0;
		while (state !== s && k < 3000) begin
			@(posedge pclk);
			k++;
		end
		chk({30'h0, state}, {30'h0, s});
		if (state !== s) complete_run();
	endtask : wait_state
	task automatic smp;
		u_ate_far_model.pulse(0);
		u_ate_far_model.pulse(1);
	endtask : smp

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		tb20_tick = 1'b0;
		tdiv = 3'h0;
		conv_cnt = 0;
		fail_count = 0;
		check_count = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ra[i]) rd(ra[i], rv[i], 32'hFFFFFFFF);
		rd(8'h30, 32'h00000000, 32'hFFFFFFFF);
		chk({31'h0, erv}, 32'h00000001);
		// Internal pacing, finite, four channels, two samples
		wr(`ATE_CTRL_OFS, 32'h0001CE81);
		chk({29'h0, term_oe}, 32'h00000007);
		wr(`ATE_SRC_OFS, 32'h00000000);
		wr(`ATE_NCHAN_OFS, 32'h00000004);
		wr(`ATE_SCNT_OFS, 32'h00000002);
		base = conv_cnt;
		wr(`ATE_CMD_OFS, 32'h00000001);
		wr(`ATE_NCHAN_OFS, 32'h00000002);
		rd(`ATE_NCHAN_OFS, 32'h00000004, 32'hFFFFFFFF);
		wait_state(ATE_IDLE);
		// Last pulse is counted at this edge
		@(posedge pclk);
		chk(conv_cnt - base, 32'd8);
		rd(`ATE_STAT_OFS, 32'h00020000, 32'hFFFF0000);
		rd(`ATE_BUF_OFS, 32'h00000003, 32'hFFFFFFFF);
		rd(`ATE_BUF_OFS, 32'h00000007, 32'hFFFFFFFF);
		rd(`ATE_STAT_OFS, 32'h00000000, 32'hFFFF0000);
		// External pacing: stray pulses before begin and out of order
		wr(`ATE_CTRL_OFS, 32'h0001C000);
		wr(`ATE_SRC_OFS, 32'h00000100);
		wr(`ATE_NCHAN_OFS, 32'h00000002);
		base = conv_cnt;
		smp();
		wr(`ATE_CMD_OFS, 32'h00000001);
		wait_state(ATE_RUN);
		chk({31'h0, hold_done_strobe}, 32'h00000001);
		chk(conv_cnt - base, 32'd0);
		foreach (seq[i]) u_ate_far_model.pulse(seq[i]);
		chk(conv_cnt - base, 32'd4);
		wr(`ATE_CMD_OFS, 32'h00000002);
		rd(`ATE_STAT_OFS, 32'h00000000, 32'h00000003);
		// Reference mode: two pretrigger, buffer of four
		wr(`ATE_CTRL_OFS, 32'h0001C083);
		wr(`ATE_SRC_OFS, 32'h00000108);
		wr(`ATE_NCHAN_OFS, 32'h00000001);
		wr(`ATE_PRE_OFS, 32'h00000002);
		wr(`ATE_BSIZE_OFS, 32'h00000004);
		wr(`ATE_CMD_OFS, 32'h00000001);
		wait_state(ATE_RUN);
		smp();
		u_ate_far_model.pulse(2);
		repeat (4) smp();
		u_ate_far_model.pulse(2);
		smp();
		rd(`ATE_STAT_OFS, 32'h00000002, 32'h00000003);
		smp();
		rd(`ATE_STAT_OFS, 32'h00040050, 32'hFFFF0053);
		// One terminal paces both samples and conversions
		wr(`ATE_CTRL_OFS, 32'h0001C180);
		wr(`ATE_SRC_OFS, 32'h00000000);
		wr(`ATE_NCHAN_OFS, 32'h00000002);
		wr(`ATE_CMD_OFS, 32'h00000001);
		wait_state(ATE_RUN);
		base = conv_cnt;
		repeat (4) u_ate_far_model.pulse(0);
		chk(conv_cnt - base, 32'd4);
		wr(`ATE_CMD_OFS, 32'h00000002);
		// Falling begin edge on terminal 2, pause high on terminal 3
		wr(`ATE_CTRL_OFS, 32'h0001CEEC);
		wr(`ATE_SRC_OFS, 32'h00000432);
		u_ate_far_model.level(3, 1'b1);
		wr(`ATE_CMD_OFS, 32'h00000001);
		u_ate_far_model.level(2, 1'b1);
		rd(`ATE_STAT_OFS, 32'h00000001, 32'h00000003);
		u_ate_far_model.level(2, 1'b0);
		wait_state(ATE_RUN);
		base = conv_cnt;
		repeat (60) @(posedge pclk);
		chk(conv_cnt - base, 32'd0);
		u_ate_far_model.level(3, 1'b0);
		repeat (200) @(posedge pclk);
		chk(32'(conv_cnt - base > 0), 32'd1);
		wr(`ATE_CMD_OFS, 32'h00000002);
		complete_run();
	end
endmodule : acquisition_timing_engine_tb
